// >>> sfr_map_reset_flags.sv
// Purpose: Special register bank with reset-cause flags, Avalon-MM slave
// Assumes: mclk 40 MHz; rst_n synchronous; strap levels are asynchronous
// Notes:   Byte space at 4*index, bit space at 0x400 + 4*bit address
//
// Behaviour
// - Power-up sets the power-on flag
// - Brownout or power-up sets the brownout flag
// - Reset leaves both supply flags unchanged
// - Reset clears power control low four bits
// - Port reset level follows configuration strap
// - Unimplemented bits carry no stored state
// - Watchdog control reset value depends on cause
// - Bit addressable registers allow single-bit access
//
// Added by the designer: the Avalon-MM register port.
`include "sfr_bank_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sfr_map_reset_flags #(
    parameter logic [7:0] WATCHDOG_CONTROL_RST_WD_CAUSE = 8'h3F,
    parameter logic [7:0] WATCHDOG_CONTROL_RST_WD_ON = 8'h1F,
    parameter logic [7:0] WATCHDOG_CONTROL_RST_WD_OFF = 8'h00
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [10:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Supply monitor, reset-cause and strap levels
    input wire logic power_up_detect,
    input wire logic brownout_detect,
    input wire logic watchdog_reset_cause,
    input wire logic watchdog_enabled_cfg,
    input wire logic port_reset_level_select,
    // Register contents for the core
    output logic [7:0] port0_pins,
    output logic [7:0] port1_pins,
    output logic [7:0] port2_pins,
    output logic [7:0] power_control,
    output logic [7:0] watchdog_control,
    // Interrupt
    output logic irq
);

    // ==================================================================
    // Decoding functions

    // Implemented bits of each stored register; zero means unmapped
    function automatic logic [7:0] impl_mask(input logic [7:0] off);
        unique case (off)
            `OFF_PORT0_PINS, `OFF_STACK_POINTER, `OFF_PORT0_MODE_A,
            `OFF_PORT0_MODE_B, `OFF_KEYPAD_IRQ_MASK, `OFF_POWER_CONTROL,
            `OFF_TIMER_RUN_FLAGS, `OFF_TIMER_MODE_SELECT, `OFF_TIMER0_LOW,
            `OFF_TIMER1_LOW, `OFF_TIMER0_HIGH, `OFF_TIMER1_HIGH,
            `OFF_PORT1_PINS, `OFF_SERIAL_CONTROL, `OFF_SERIAL_BUFFER,
            `OFF_PORT2_MODE_CLK, `OFF_WATCHDOG_FEED,
            `OFF_SERIAL_MATCH_ADDR, `OFF_SERIAL_MATCH_MASK,
            `OFF_PROGRAM_STATUS, `OFF_PORT0_DIGIN_OFF:
                impl_mask = `MASK_FULL;
            `OFF_PORT1_MODE_A, `OFF_PORT1_MODE_B:
                impl_mask = `MASK_PORT1_MODE;
            `OFF_PORT2_PINS, `OFF_PORT2_MODE_B:
                impl_mask = `MASK_PORT2;
            `OFF_WATCHDOG_CONTROL:
                impl_mask = `MASK_WATCHDOG_CONTROL;
            `OFF_IRQ_PRIO1_HIGH, `OFF_IRQ_PRIO1:
                impl_mask = `MASK_IRQ_PRIO1;
            default:
                impl_mask = `RST_ZERO;
        endcase
    endfunction

    // Bits that keep their contents through reset
    function automatic logic [7:0] keep_mask(input logic [7:0] off);
        unique case (off)
            `OFF_POWER_CONTROL:
                keep_mask = `POWER_CONTROL_KEEP_MASK;
            `OFF_SERIAL_BUFFER, `OFF_WATCHDOG_FEED:
                keep_mask = `MASK_FULL;
            default:
                keep_mask = `RST_ZERO;
        endcase
    endfunction

    // Reset value for the bits not kept
    function automatic logic [7:0] reset_val(
        input logic [7:0] off,
        input logic port_high,
        input sfr_bank_pkg::wd_cause_t cause
    );
        unique case (off)
            `OFF_STACK_POINTER:
                reset_val = `RST_STACK_POINTER;
            `OFF_PORT0_PINS, `OFF_PORT1_PINS, `OFF_PORT2_PINS:
                reset_val = port_high ? `RST_PORT_HIGH : `RST_ZERO;
            `OFF_WATCHDOG_CONTROL:
            begin
                unique case (cause)
                    sfr_bank_pkg::CAUSE_WATCHDOG:
                        reset_val = WATCHDOG_CONTROL_RST_WD_CAUSE;
                    sfr_bank_pkg::CAUSE_OTHER_WD_ON:
                        reset_val = WATCHDOG_CONTROL_RST_WD_ON;
                    default:
                        reset_val = WATCHDOG_CONTROL_RST_WD_OFF;
                endcase
            end
            default:
                reset_val = `RST_ZERO;
        endcase
    endfunction

    // Registers that accept single-bit access
    function automatic logic bit_addressable(input logic [7:0] off);
        unique case (off)
            `OFF_PORT0_PINS, `OFF_TIMER_RUN_FLAGS, `OFF_PORT1_PINS,
            `OFF_SERIAL_CONTROL, `OFF_PORT2_PINS, `OFF_PROGRAM_STATUS,
            `OFF_IRQ_PRIO1:
                bit_addressable = 1'b1;
            default:
                bit_addressable = 1'b0;
        endcase
    endfunction

    // ==================================================================
    // Synchronised external levels

    logic [4:0] async_levels;
    logic [4:0] sync_levels;
    logic [4:0] sync_rises;
    sfr_bank_pkg::supply_evt_t supply_rise;
    sfr_bank_pkg::wd_cause_t cause_now;
    logic port_high_now;

    assign async_levels = {port_reset_level_select, watchdog_enabled_cfg,
                           watchdog_reset_cause, brownout_detect,
                           power_up_detect};

    sfr_pin_sync #(
        .WIDTH(5)
    ) u_pin_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in(async_levels),
        .level_out(sync_levels),
        .rise_out(sync_rises)
    );

    // Supply events and straps as seen by the bank
    assign supply_rise.power_up = sync_rises[0];
    assign supply_rise.brownout = sync_rises[1];
    assign port_high_now = sync_levels[4];

    // Reset cause seen while reset is held
    always_comb
    begin
        if (sync_levels[2])
            cause_now = sfr_bank_pkg::CAUSE_WATCHDOG;
        else if (sync_levels[3])
            cause_now = sfr_bank_pkg::CAUSE_OTHER_WD_ON;
        else
            cause_now = sfr_bank_pkg::CAUSE_OTHER_WD_OFF;
    end

    // ==================================================================
    // Bus decode

    sfr_bank_pkg::sfr_access_t acc;
    logic req_live;
    logic done_reg;
    logic [7:0] tgt_off;
    logic [7:0] cur_byte;
    logic [7:0] wr_mask;
    logic [7:0] wr_byte;
    logic do_write;
    logic evt_hit;

    // Split byte space and bit space; misaligned words are unmapped
    always_comb
    begin
        acc.bit_op = address[`BIT_SPACE_SEL];
        acc.index = address[9:2];
        acc.bit_sel = address[4:2];
        tgt_off = acc.bit_op ? {acc.index[7:3], 3'b000} : acc.index;
        if (address[1:0] != 2'b00 || !address[9])
            acc.hit = 1'b0;
        else if (acc.bit_op)
            acc.hit = bit_addressable(tgt_off);
        else
            acc.hit = 1'b1;
    end

    // Answer one cycle after the request is seen
    assign req_live = (read || write) && !done_reg;
    assign waitrequest = req_live;
    assign evt_hit = !acc.bit_op && (tgt_off == `OFF_EVENT_STATUS
                                     || tgt_off == `OFF_EVENT_MASK);

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            done_reg <= 1'b0;
        else
            done_reg <= req_live;
    end

    // ==================================================================
    // Register storage, indexed by offset minus 0x80

    logic [7:0] sfr_mem [0:127];

    assign cur_byte = sfr_mem[tgt_off[6:0]] & impl_mask(tgt_off);
    assign do_write = req_live && write && byteenable[0] && acc.hit
                      && !evt_hit;

    // Byte writes cover all implemented bits, bit writes one bit
    always_comb
    begin
        wr_mask = impl_mask(tgt_off);
        wr_byte = writedata[7:0];
        if (acc.bit_op)
        begin
            wr_mask = wr_mask & (8'h01 << acc.bit_sel);
            wr_byte = {8{writedata[0]}};
        end
    end

    // Reset load, bus writes, then hardware flag sets which win
    // A supply level held through reset counts as its event
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < 128; i++)
        begin
            if (!rst_n)
                sfr_mem[i] <= (sfr_mem[i] & keep_mask({1'b1, 7'(i)}))
                    | (reset_val({1'b1, 7'(i)}, port_high_now, cause_now)
                       & ~keep_mask({1'b1, 7'(i)}));
            else if (do_write && tgt_off[6:0] == 7'(i))
                sfr_mem[i] <= (sfr_mem[i] & ~wr_mask) | (wr_byte & wr_mask);
        end
        if (supply_rise.power_up || (!rst_n && sync_levels[0]))
        begin
            sfr_mem[7'(`OFF_POWER_CONTROL)][`POWER_CONTROL_POWER_ON_BIT] <= 1'b1;
            sfr_mem[7'(`OFF_POWER_CONTROL)][`POWER_CONTROL_BROWNOUT_BIT] <= 1'b1;
        end
        if (supply_rise.brownout || (!rst_n && sync_levels[1]))
            sfr_mem[7'(`OFF_POWER_CONTROL)][`POWER_CONTROL_BROWNOUT_BIT] <= 1'b1;
    end

    // ==================================================================
    // Event status and mask

    logic [`EVT_WIDTH-1:0] evt_status_reg;
    logic [`EVT_WIDTH-1:0] evt_mask_reg;
    logic [`EVT_WIDTH-1:0] evt_set;
    logic status_read;

    assign evt_set = {supply_rise.brownout | supply_rise.power_up,
                      supply_rise.power_up};
    assign status_read = req_live && read && !acc.bit_op
                         && tgt_off == `OFF_EVENT_STATUS;

    // Sticky bits, cleared by a read; a new event wins over the clear
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            evt_status_reg <= '0;
        else if (status_read)
            evt_status_reg <= evt_set;
        else
            evt_status_reg <= evt_status_reg | evt_set;
    end

    // Mask register, one enable per status bit
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            evt_mask_reg <= '0;
        else if (req_live && write && byteenable[0] && !acc.bit_op
                 && tgt_off == `OFF_EVENT_MASK)
            evt_mask_reg <= writedata[`EVT_WIDTH-1:0];
    end

    // Level interrupt while any unmasked status bit is set
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(evt_status_reg & evt_mask_reg);
    end

    // ==================================================================
    // Read data

    // Captured as the answer is given; unmapped reads return zero
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            readdata <= '0;
        else if (req_live && read)
        begin
            readdata <= '0;
            if (acc.hit && tgt_off == `OFF_EVENT_STATUS)
                readdata[`EVT_WIDTH-1:0] <= evt_status_reg;
            else if (acc.hit && tgt_off == `OFF_EVENT_MASK)
                readdata[`EVT_WIDTH-1:0] <= evt_mask_reg;
            else if (acc.hit && acc.bit_op)
                readdata[0] <= cur_byte[acc.bit_sel];
            else if (acc.hit)
                readdata[7:0] <= cur_byte;
        end
    end

    // ==================================================================
    // Register contents towards the core

    // Copies of stored values; implemented bits only
    always_ff @(posedge mclk)
    begin
        port0_pins <= sfr_mem[7'(`OFF_PORT0_PINS)];
        port1_pins <= sfr_mem[7'(`OFF_PORT1_PINS)];
        port2_pins <= sfr_mem[7'(`OFF_PORT2_PINS)] & `MASK_PORT2;
        power_control <= sfr_mem[7'(`OFF_POWER_CONTROL)];
        watchdog_control <= sfr_mem[7'(`OFF_WATCHDOG_CONTROL)]
                            & `MASK_WATCHDOG_CONTROL;
    end

endmodule // sfr_map_reset_flags

`default_nettype wire

// >>> sfr_bank_cfg.svh
// Purpose: Offsets, field positions and reset values of the register bank
// Assumes: Register index = printed offset; byte address = 4 * index
// Notes:   Bit space sits at byte address 0x400 + 4 * bit address
`ifndef SFR_BANK_CFG_SVH
`define SFR_BANK_CFG_SVH

// ======================================================================
// Register indices
`define OFF_PORT0_PINS 8'h80
`define OFF_STACK_POINTER 8'h81
`define OFF_PORT0_MODE_A 8'h84
`define OFF_PORT0_MODE_B 8'h85
`define OFF_KEYPAD_IRQ_MASK 8'h86
`define OFF_POWER_CONTROL 8'h87
`define OFF_TIMER_RUN_FLAGS 8'h88
`define OFF_TIMER_MODE_SELECT 8'h89
`define OFF_TIMER0_LOW 8'h8A
`define OFF_TIMER1_LOW 8'h8B
`define OFF_TIMER0_HIGH 8'h8C
`define OFF_TIMER1_HIGH 8'h8D
`define OFF_PORT1_PINS 8'h90
`define OFF_PORT1_MODE_A 8'h91
`define OFF_PORT1_MODE_B 8'h92
`define OFF_SERIAL_CONTROL 8'h98
`define OFF_SERIAL_BUFFER 8'h99
`define OFF_PORT2_PINS 8'hA0
`define OFF_PORT2_MODE_CLK 8'hA4
`define OFF_PORT2_MODE_B 8'hA5
`define OFF_WATCHDOG_FEED 8'hA6
`define OFF_WATCHDOG_CONTROL 8'hA7
`define OFF_SERIAL_MATCH_ADDR 8'hA9
`define OFF_SERIAL_MATCH_MASK 8'hB9
`define OFF_PROGRAM_STATUS 8'hD0
`define OFF_PORT0_DIGIN_OFF 8'hF6
`define OFF_IRQ_PRIO1_HIGH 8'hF7
`define OFF_IRQ_PRIO1 8'hF8
`define OFF_EVENT_STATUS 8'hFA
`define OFF_EVENT_MASK 8'hFB

// ======================================================================
// Implemented-bit masks of partly and fully populated registers
`define MASK_IRQ_PRIO1 8'hB7
`define MASK_PORT1_MODE 8'hD3
`define MASK_PORT2 8'h03
`define MASK_WATCHDOG_CONTROL 8'h3F
`define MASK_FULL 8'hFF

// ======================================================================
// Power control fields and register reset values
`define POWER_CONTROL_BROWNOUT_BIT 5
`define POWER_CONTROL_POWER_ON_BIT 4
`define POWER_CONTROL_KEEP_MASK 8'hF0
`define RST_STACK_POINTER 8'h07
`define RST_ZERO 8'h00
`define RST_PORT_HIGH 8'hFF

// ======================================================================
// Event status bits and access layout
`define EVT_POWER_UP_BIT 0
`define EVT_BROWNOUT_BIT 1
`define EVT_WIDTH 2
`define BIT_SPACE_SEL 10

`endif

// >>> sfr_bank_pkg.sv
// Purpose: Types shared by the register bank files
// Assumes: Constants come from sfr_bank_cfg.svh
// Notes:   Types only
`default_nettype none

package sfr_bank_pkg;

    // ==================================================================
    // Supply events as seen after synchronising
    typedef struct packed {
        logic brownout;
        logic power_up;
    } supply_evt_t;

    // Cause recorded for the watchdog control reset value
    typedef enum logic [1:0] {
        CAUSE_WATCHDOG,
        CAUSE_OTHER_WD_ON,
        CAUSE_OTHER_WD_OFF
    } wd_cause_t;

    // Decoded bus access
    typedef struct packed {
        logic hit;
        logic bit_op;
        logic [7:0] index;
        logic [2:0] bit_sel;
    } sfr_access_t;

endpackage

`default_nettype wire

// >>> sfr_pin_sync.sv
// Purpose: Three-stage synchroniser for levels from outside mclk
// Assumes: One clock, synchronous reset
// Notes:   The filtered level moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module sfr_pin_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Asynchronous levels in
    input wire logic [WIDTH-1:0] async_in,
    // Filtered level and its rising pulse
    output logic [WIDTH-1:0] level_out,
    output logic [WIDTH-1:0] rise_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;

    // Shift chain; stage one feeds only stage two
    always_ff @(posedge mclk)
    begin
        stage1_reg <= async_in;
        stage2_reg <= stage1_reg;
        stage3_reg <= stage2_reg;
    end

    // Accept a change once the two later stages agree
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            if (stage2_reg[i] == stage3_reg[i])
                level_reg[i] <= stage3_reg[i];
        end
    end

    // Pulse on a rising filtered level
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            rise_out <= '0;
        else
            rise_out <= ~level_reg & stage3_reg & stage2_reg;
    end

    assign level_out = level_reg;

endmodule // sfr_pin_sync

`default_nettype wire

// >>> sfr_map_reset_flags_chk.sv
// Purpose: Port-level checks of the register bank reset and bus behaviour
// Assumes: One clock mclk, synchronous active-low rst_n
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ps
`default_nettype none

module sfr_map_reset_flags_chk #(
    parameter logic [7:0] WATCHDOG_CONTROL_RST_WD_CAUSE = 8'h3F,
    parameter logic [7:0] WATCHDOG_CONTROL_RST_WD_ON = 8'h1F,
    parameter logic [7:0] WATCHDOG_CONTROL_RST_WD_OFF = 8'h00
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Bus
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Supply and straps
    input wire logic power_up_detect,
    input wire logic brownout_detect,
    input wire logic watchdog_reset_cause,
    input wire logic watchdog_enabled_cfg,
    input wire logic port_reset_level_select,
    // Register copies and interrupt
    input wire logic [7:0] port0_pins,
    input wire logic [7:0] power_control,
    input wire logic [7:0] watchdog_control,
    input wire logic irq
);
    // ==================================================================
    // Helper state
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    logic seen_run = 1'b0;

    // Marks that one reset has been left, so flags are defined
    always_ff @(posedge mclk)
    begin
        seen_run <= seen_run | rst_n;
    end

    // ==================================================================
    // Assertions
    wait_one_a: assert property ((read || write) && waitrequest
        |=> !waitrequest)
        else $error("waitrequest held longer than one cycle");
    read_upper_a: assert property (read && !waitrequest
        |-> readdata[31:8] == 24'h0)
        else $error("read data upper bytes not zero");
    pof_set_a: assert property ($rose(power_up_detect)
        |-> ##[1:10] power_control[4])
        else $error("power-on flag not set after power-up");
    bof_brown_a: assert property ($rose(brownout_detect)
        |-> ##[1:10] power_control[5])
        else $error("brownout flag not set after brownout");
    bof_pwr_a: assert property ($rose(power_up_detect)
        |-> ##[1:10] power_control[5])
        else $error("brownout flag not set after power-up");
    flags_kept_a: assert property (disable iff (1'b0) seen_run
        && !rst_n && !power_up_detect && !brownout_detect
        |=> power_control[5:4] == $past(power_control[5:4]))
        else $error("supply flags changed by reset");
    power_control_low_a: assert property (disable iff (1'b0) !rst_n
        ##1 rst_n |=> power_control[3:0] == 4'h0)
        else $error("power control low bits not cleared");
    port_level_a: assert property (disable iff (1'b0) !rst_n
        ##1 rst_n |=> port0_pins
        == (port_reset_level_select ? 8'hFF : 8'h00))
        else $error("port reset level wrong");
    wd_reset_a: assert property (disable iff (1'b0) !rst_n
        ##1 rst_n |=> watchdog_control
        == (watchdog_reset_cause ? WATCHDOG_CONTROL_RST_WD_CAUSE
        : watchdog_enabled_cfg ? WATCHDOG_CONTROL_RST_WD_ON : WATCHDOG_CONTROL_RST_WD_OFF))
        else $error("watchdog control reset value wrong");
    irq_reset_a: assert property (disable iff (1'b0) !rst_n
        ##1 rst_n |-> !irq)
        else $error("interrupt high after reset");
endmodule // sfr_map_reset_flags_chk

bind sfr_map_reset_flags sfr_map_reset_flags_chk #(
    .WATCHDOG_CONTROL_RST_WD_CAUSE(WATCHDOG_CONTROL_RST_WD_CAUSE),
    .WATCHDOG_CONTROL_RST_WD_ON(WATCHDOG_CONTROL_RST_WD_ON),
    .WATCHDOG_CONTROL_RST_WD_OFF(WATCHDOG_CONTROL_RST_WD_OFF)
) i_chk (.mclk(mclk), .rst_n(rst_n), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest),
    .power_up_detect(power_up_detect), .brownout_detect(brownout_detect),
    .watchdog_reset_cause(watchdog_reset_cause),
    .watchdog_enabled_cfg(watchdog_enabled_cfg),
    .port_reset_level_select(port_reset_level_select),
    .port0_pins(port0_pins), .power_control(power_control),
    .watchdog_control(watchdog_control), .irq(irq));

`default_nettype wire

// >>> sfr_map_reset_flags_tb_top.sv
// Purpose: Self-checking bench for the register bank over Avalon-MM
// Assumes: 40 MHz mclk, one wait cycle per access
// Notes:   Straps move only well away from reset edges
`include "sfr_bank_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sfr_map_reset_flags_tb_top;
    localparam logic [7:0] WD_C = 8'h3F;
    localparam logic [7:0] WD_ON = 8'h1F;
    localparam logic [7:0] WD_OFF = 8'h00;
    logic mclk, rst_n, read, write, waitrequest, irq;
    logic [10:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    logic power_up_detect, brownout_detect, watchdog_reset_cause;
    logic watchdog_enabled_cfg, port_reset_level_select;
    logic [7:0] port0_pins, port1_pins, port2_pins, power_control;
    logic [7:0] watchdog_control, q;
    int err_total = 0;
    int checks_done = 0;
    logic [7:0] zero_regs [18] = '{8'h84, 8'h85, 8'h86, 8'h88, 8'h89,
        8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h91, 8'h92, 8'h98, 8'hA4, 8'hA5,
        8'hA9, 8'hB9, 8'hD0, 8'hF6};
    logic [7:0] bit_regs [7] = '{8'h80, 8'h88, 8'h90, 8'h98, 8'hA0,
        8'hD0, 8'hF8};

    sfr_map_reset_flags #(.WATCHDOG_CONTROL_RST_WD_CAUSE(WD_C),
        .WATCHDOG_CONTROL_RST_WD_ON(WD_ON), .WATCHDOG_CONTROL_RST_WD_OFF(WD_OFF)) i_dut (
        .mclk(mclk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .power_up_detect(power_up_detect),
        .brownout_detect(brownout_detect),
        .watchdog_reset_cause(watchdog_reset_cause),
        .watchdog_enabled_cfg(watchdog_enabled_cfg),
        .port_reset_level_select(port_reset_level_select),
        .port0_pins(port0_pins), .port1_pins(port1_pins),
        .port2_pins(port2_pins), .power_control(power_control),
        .watchdog_control(watchdog_control), .irq(irq));

    // ==================================================================
    // Tasks
    task automatic end_sim();
        if (err_total == 0 && checks_done > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus access; request held until waitrequest is seen low
    task automatic xfer(input logic [10:0] a, input logic wr,
        input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge mclk);
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        read <= !wr;
        write <= wr;
        @(posedge mclk);
        while (waitrequest)
        begin
            n++;
            if (n > 50)
            begin
                err_total++;
                end_sim();
            end
            @(posedge mclk);
        end
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer({1'b0, idx, 2'b00}, 1'b1, d, 4'hF);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] m,
        input logic [7:0] exp);
        xfer({1'b0, idx, 2'b00}, 1'b0, 8'h00, 4'hF);
        check8(q & m, exp);
    endtask

    task automatic do_reset(input int n);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (n) @(posedge mclk);
        rst_n <= 1'b1;
    endtask

    // ==================================================================
    // Clock and hang guard
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Cuts a hung run short
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_total++;
        end_sim();
    end

    // ==================================================================
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 11'h000;
        writedata = 32'h0000_0000;
        byteenable = 4'hF;
        power_up_detect = 1'b1;
        brownout_detect = 1'b0;
        watchdog_reset_cause = 1'b0;
        watchdog_enabled_cfg = 1'b1;
        port_reset_level_select = 1'b1;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        power_up_detect <= 1'b0;
        // Reset values
        rdchk(`OFF_POWER_CONTROL, 8'h3F, 8'h30);
        rdchk(`OFF_PORT0_PINS, 8'hFF, 8'hFF);
        rdchk(`OFF_PORT1_PINS, 8'hFF, 8'hFF);
        rdchk(`OFF_PORT2_PINS, 8'hFF, 8'h03);
        check8(port1_pins, 8'hFF);
        check8(port2_pins, 8'h03);
        rdchk(`OFF_WATCHDOG_CONTROL, 8'hFF, WD_ON);
        rdchk(`OFF_STACK_POINTER, 8'hFF, 8'h07);
        rdchk(`OFF_EVENT_STATUS, 8'hFF, 8'h00);
        foreach (zero_regs[i]) rdchk(zero_regs[i], 8'hFF, 8'h00);
        // Unimplemented bits, unmapped writes, misaligned reads and masked writes
        wr(`OFF_IRQ_PRIO1, 8'hFF);
        rdchk(`OFF_IRQ_PRIO1, 8'hFF, 8'hB7);
        wr(`OFF_PORT1_MODE_A, 8'hFF);
        rdchk(`OFF_PORT1_MODE_A, 8'hFF, 8'hD3);
        wr(8'h82, 8'hFF);
        rdchk(8'h82, 8'hFF, 8'h00);
        xfer(11'h201, 1'b0, 8'h00, 4'hF);
        check8(q, 8'h00);
        xfer({1'b0, `OFF_TIMER_MODE_SELECT, 2'b00}, 1'b1, 8'hAA, 4'h0);
        rdchk(`OFF_TIMER_MODE_SELECT, 8'hFF, 8'h00);
        // Single-bit access on every bit-addressable register
        foreach (bit_regs[i])
        begin
            wr(bit_regs[i], 8'h00);
            xfer({1'b1, bit_regs[i] | 8'h01, 2'b00}, 1'b1, 8'h01, 4'hF);
            rdchk(bit_regs[i], 8'hFF, 8'h02);
            xfer({1'b1, bit_regs[i] | 8'h01, 2'b00}, 1'b0, 8'h00, 4'hF);
            check8(q, 8'h01);
        end
        check8(port0_pins, 8'h02);
        // Supply events, status, mask and interrupt
        wr(`OFF_POWER_CONTROL, 8'h00);
        rdchk(`OFF_POWER_CONTROL, 8'h3F, 8'h00);
        wr(`OFF_EVENT_MASK, 8'h02);
        brownout_detect <= 1'b1;
        repeat (10) @(posedge mclk);
        check8({7'h0, irq}, 8'h01);
        rdchk(`OFF_POWER_CONTROL, 8'h3F, 8'h20);
        rdchk(`OFF_EVENT_STATUS, 8'hFF, 8'h02);
        repeat (3) @(posedge mclk);
        check8({7'h0, irq}, 8'h00);
        brownout_detect <= 1'b0;
        wr(`OFF_EVENT_MASK, 8'h00);
        power_up_detect <= 1'b1;
        repeat (10) @(posedge mclk);
        check8({7'h0, irq}, 8'h00);
        rdchk(`OFF_POWER_CONTROL, 8'h3F, 8'h30);
        rdchk(`OFF_EVENT_STATUS, 8'hFF, 8'h03);
        power_up_detect <= 1'b0;
        // Mid-run resets with other strap settings
        wr(`OFF_POWER_CONTROL, 8'h3F);
        port_reset_level_select <= 1'b0;
        watchdog_reset_cause <= 1'b1;
        repeat (8) @(posedge mclk);
        do_reset(5);
        rdchk(`OFF_POWER_CONTROL, 8'h3F, 8'h30);
        check8(power_control & 8'h3F, 8'h30);
        rdchk(`OFF_PORT0_PINS, 8'hFF, 8'h00);
        rdchk(`OFF_WATCHDOG_CONTROL, 8'hFF, WD_C);
        watchdog_reset_cause <= 1'b0;
        watchdog_enabled_cfg <= 1'b0;
        repeat (8) @(posedge mclk);
        do_reset(5);
        rdchk(`OFF_WATCHDOG_CONTROL, 8'hFF, WD_OFF);
        end_sim();
    end
endmodule // sfr_map_reset_flags_tb_top

`default_nettype wire
